// [rtl/cms_cfg.svh]
/*
 * Timing counts and index limits for the cache maintenance sequencer.
 * Assumes one processor clock; every timing count is in clocks of that clock.
 */
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH

// Execute-stage clocks of each invalidate, drain time excluded.
`define INV_LINE_CLKS 9'h009
`define INV_PAGE_CLKS 9'h10A
`define INV_ALL_CLKS 9'h009

// Best-case execute clocks of the push variants.
`define PUSH_LINE_BEST 9'h006
`define PUSH_PAGE_BEST 9'h10B

// Lines handed over by one push variant.
`define PUSH_LINE_LINES 9'h001
`define PUSH_PAGE_LINES 9'h100

// Set-up clocks before the first index; one clock is kept for the end.
`define PUSH_LINE_PRE (`PUSH_LINE_BEST - `PUSH_LINE_LINES - 9'h001)
`define PUSH_PAGE_PRE (`PUSH_PAGE_BEST - `PUSH_PAGE_LINES - 9'h001)

// Longword beats of a line transfer, less one.
`define LINE_BEATS_M1 2'h3

`endif

// [rtl/cms_pkg.sv]
/*
 * Types shared by the cache maintenance sequencer and its bench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cms_pkg;

    // Maintenance operation issued by the pipeline.
    typedef enum logic [2:0] {
        line_invalidate_op = 3'h0,
        page_invalidate_op = 3'h1,
        whole_cache_invalidate_op = 3'h2,
        line_push_op = 3'h3,
        page_push_op = 3'h4,
        whole_cache_push_op = 3'h5
    } op_e;

    // Push command handed to the external bus side.
    typedef struct packed {
        logic line_xfer;
        logic [7:0] index;
        logic [3:0] dirty;
    } push_cmd_s;

endpackage

// [rtl/cache_maintenance_sequencer.sv]
/*
 * Cache maintenance sequencer: execute-stage timing of the invalidate and
 * push operations, the data-cache line checker with its push buffer, and
 * the start of the external push transfers.
 * Assumes the cache array answers dirty_mask combinationally for chk_index,
 * and that the bus acknowledge arrives from a pin, one pulse per longword.
 */
// Notes on behaviour
// [R1] Line invalidate: nine clocks plus drain.
// [R2] Page invalidate: 266 clocks plus drain.
// [R3] Whole invalidate: nine clocks plus drain.
// [R4] Invalidate waits for writes and prefetches.
// [R5] Cache selection never changes invalidate time.
// [R6] Address stage held; released on completion.
// [R7] Line push: six clocks, more if dirty.
// [R8] Page/whole push: 267 clocks best case.
// [R9] One index per clock, way-minor order.
// [R10] After last index, wait pushes done.
// [R11] No next instruction during a push.
// [R12] Dirty check loads half, then half.
// [R13] Dirty check repeats until buffer free.
// [R14] Clean or loaded line advances index.
// [R15] Single dirty longword written alone.
// [R16] Line transfer; buffer freed first beat.
// [R17] Transfer starts clock after second half; code starts it later while a transfer is running.
// [R18] Clean checks overlap running transfers.
// [R19] After line push, wait next start.
// [R20] One-clock completion pulse to pipeline.
`timescale 1ns/1ps
`include "cms_cfg.svh"

module cache_maintenance_sequencer
    import cms_pkg::*;
#(
    parameter int IDX_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire op_e op_kind,
    input wire logic [1:0] cache_sel,
    input wire logic [IDX_W-1:0] line_index,
    input wire logic writes_pending,
    input wire logic prefetch_pending,
    input wire logic [3:0] dirty_mask,
    input wire logic bus_cycle_acknowledge,
    output logic op_ready,
    output logic exec_busy,
    output logic eac_hold,
    output logic op_done,
    output logic chk_valid,
    output logic [IDX_W-1:0] chk_index,
    output logic buf_load_lo,
    output logic buf_load_hi,
    output logic transfer_start_strobe,
    output push_cmd_s push_cmd
);

    // ************************************************************
    // Types of the local state machines
    // ************************************************************

    typedef enum logic [2:0] {
        E_IDLE = 3'h0,
        E_DRAIN = 3'h1,
        E_COUNT = 3'h2,
        E_PRE = 3'h3,
        E_ISSUE = 3'h4,
        E_WAIT = 3'h5
    } eu_state_e;

    typedef enum logic [0:0] {
        C_CHECK = 1'h0,
        C_HI = 1'h1
    } chk_state_e;

    typedef enum logic [1:0] {
        B_EMPTY = 2'h0,
        B_HALF = 2'h1,
        B_FULL = 2'h2,
        B_SENT = 2'h3
    } buf_state_e;

    // ************************************************************
    // State
    // ************************************************************

    eu_state_e eu_q, eu_d;
    chk_state_e chk_q, chk_d;
    buf_state_e buf_q, buf_d;
    logic [8:0] cnt_q, cnt_d;
    logic [IDX_W-1:0] idx_q, idx_d;
    logic [IDX_W-1:0] idx_end_q, idx_end_d;
    logic bus_busy_q, bus_busy_d;
    logic bus_line_q, bus_line_d;
    logic [1:0] beats_q, beats_d;
    push_cmd_s cmd_q, cmd_d;
    logic ack_s1_q, ack_s2_q;

    // ************************************************************
    // Decoding
    // ************************************************************

    // The cache selection is deliberately not decoded: every selection
    // walks the same sequence, so the time does not depend on it.
    logic [1:0] sel_unused;
    assign sel_unused = cache_sel; // see [R5]

    logic is_inv;
    logic is_line;
    logic [8:0] inv_clks;
    logic [8:0] pre_clks;
    logic drained;
    logic ack;
    logic dirty;
    logic single;
    logic r19_block;
    logic load_lo;
    logic chk_adv;
    logic idx_last;
    logic ts_fire;
    logic push_idle;
    logic first_ack;

    assign is_inv = (op_kind == line_invalidate_op) ||
                    (op_kind == page_invalidate_op) ||
                    (op_kind == whole_cache_invalidate_op);
    assign is_line = (op_kind == line_push_op);

    // Invalidate length per variant.
    assign inv_clks = (op_kind == page_invalidate_op) ? `INV_PAGE_CLKS : // see [R2]
                      (op_kind == line_invalidate_op) ? `INV_LINE_CLKS : // see [R1]
                      `INV_ALL_CLKS; // see [R3]

    // Set-up clocks ahead of the first index of a push.
    assign pre_clks = is_line ? `PUSH_LINE_PRE : `PUSH_PAGE_PRE; // see [R7] [R8]
    // Drain is complete once no write and no prefetch is outstanding.
    assign drained = !writes_pending && !prefetch_pending;
    // Acknowledge comes from a pin and is used only after two flops.
    assign ack = ack_s2_q;
    // One dirty longword is written alone, anything more as a line.
    assign dirty = |dirty_mask;
    assign single = dirty && ((dirty_mask & (dirty_mask - 4'h1)) == 4'h0); // see [R15]
    // A loaded line behind a running line transfer holds up all checks,
    // clean ones included, until its own transfer has started.
    assign r19_block = (buf_q == B_FULL) && bus_busy_q && bus_line_q; // see [R19]
    // A check is made while an index is pending and nothing blocks it.
    assign chk_valid = (eu_q == E_ISSUE) && (chk_q == C_CHECK) && !r19_block;
    assign chk_index = idx_q;
    // Dirty line with a free buffer: first half loads in the check clock.
    assign load_lo = chk_valid && dirty && (buf_q == B_EMPTY); // see [R12] [R13]
    assign buf_load_lo = load_lo;
    assign buf_load_hi = (chk_q == C_HI); // see [R12]
    // Clean lines move on at once, without the buffer.
    assign chk_adv = (chk_valid && !dirty) || (chk_q == C_HI); // see [R14] [R18]
    assign idx_last = (idx_q == idx_end_q);
    // Transfer starts once the second half is in the buffer and no transfer is running.
    assign ts_fire = (buf_q == B_FULL) && !bus_busy_q; // see [R17]
    assign transfer_start_strobe = ts_fire;

    // First acknowledge of the transfer that emptied the buffer.
    assign first_ack = ack && bus_busy_q && (buf_q == B_SENT);

    assign push_idle = (buf_q == B_EMPTY) && !bus_busy_q &&
                       (chk_q == C_CHECK);

    // Pipeline handshakes.
    assign op_ready = (eu_q == E_IDLE);
    assign exec_busy = (eu_q != E_IDLE);
    assign eac_hold = (eu_q != E_IDLE); // see [R6] [R11]
    assign push_cmd = cmd_q;

    // ************************************************************
    // Execute-stage sequence
    // ************************************************************

    // The op_done clock is the last busy clock, so the next instruction
    // is taken in the clock after it.
    always_comb begin
        eu_d = eu_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        idx_end_d = idx_end_q;
        op_done = 1'b0;
        unique case (eu_q)
            E_IDLE: begin
                if (op_valid && is_inv) begin
                    eu_d = E_DRAIN;
                    cnt_d = inv_clks;
                end else if (op_valid) begin
                    eu_d = E_PRE;
                    cnt_d = pre_clks - 9'h001;
                    idx_d = is_line ? line_index : '0; // see [R9]
                    idx_end_d = is_line ? line_index : '1;
                end
            end
            E_DRAIN: begin
                // The first clock after the drain already counts.
                if (drained) begin // see [R4]
                    eu_d = E_COUNT;
                    cnt_d = cnt_q - 9'h002;
                end
            end
            E_COUNT: begin
                if (cnt_q == 9'h000) begin
                    eu_d = E_IDLE;
                    op_done = 1'b1; // see [R20]
                end else begin
                    cnt_d = cnt_q - 9'h001;
                end
            end
            E_PRE: begin
                if (cnt_q == 9'h000) begin
                    eu_d = E_ISSUE;
                end else begin
                    cnt_d = cnt_q - 9'h001;
                end
            end
            E_ISSUE: begin
                // One index per clock while lines are clean.
                if (chk_adv && idx_last) begin
                    eu_d = E_WAIT;
                end else if (chk_adv) begin
                    idx_d = idx_q + 1'b1; // see [R9]
                end
            end
            E_WAIT: begin
                // Every push must be done before the operation ends.
                if (push_idle && drained) begin // see [R10] [R7] [R8]
                    eu_d = E_IDLE;
                    op_done = 1'b1; // see [R20]
                end
            end
            default: begin
                eu_d = E_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Line checker and push buffer
    // ************************************************************

    // The buffer frees on the first acknowledge, so a new load may
    // overlap the later beats of a line transfer.
    always_comb begin
        chk_d = chk_q;
        buf_d = buf_q;
        cmd_d = cmd_q;
        if (load_lo) begin
            chk_d = C_HI;
            buf_d = B_HALF;
            cmd_d.line_xfer = !single; // see [R15] [R16]
            cmd_d.index = 8'(idx_q);
            cmd_d.dirty = dirty_mask;
        end else if (chk_q == C_HI) begin
            chk_d = C_CHECK;
            buf_d = B_FULL;
        end else if (ts_fire) begin
            buf_d = B_SENT;
        end else if (first_ack) begin
            buf_d = B_EMPTY; // see [R16] [R13]
        end
    end

    // ************************************************************
    // External push transfer tracking
    // ************************************************************

    always_comb begin
        bus_busy_d = bus_busy_q;
        bus_line_d = bus_line_q;
        beats_d = beats_q;
        if (ts_fire) begin
            bus_busy_d = 1'b1;
            bus_line_d = cmd_q.line_xfer;
            beats_d = cmd_q.line_xfer ? `LINE_BEATS_M1 : 2'h0; // see [R16] [R15]
        end else if (ack && bus_busy_q) begin
            if (beats_q == 2'h0) begin
                bus_busy_d = 1'b0;
            end else begin
                beats_d = beats_q - 2'h1;
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************

    // Acknowledge synchroniser; the first flop feeds only the second.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= bus_cycle_acknowledge;
            ack_s2_q <= ack_s1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            eu_q <= E_IDLE;
            cnt_q <= 9'h000;
            idx_q <= '0;
            idx_end_q <= '0;
        end else begin
            eu_q <= eu_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            idx_end_q <= idx_end_d;
        end
    end

    // Buffer and bus state hand the push over between them, so they share one process.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chk_q <= C_CHECK;
            buf_q <= B_EMPTY;
            cmd_q <= '0;
            bus_busy_q <= 1'b0;
            bus_line_q <= 1'b0;
            beats_q <= 2'h0;
        end else begin
            chk_q <= chk_d;
            buf_q <= buf_d;
            cmd_q <= cmd_d;
            bus_busy_q <= bus_busy_d;
            bus_line_q <= bus_line_d;
            beats_q <= beats_d;
        end
    end

endmodule

// [test/cms_chk.sv]
/* Assertion checker for the cache maintenance sequencer.
   Assumes it is bound to the sequencer and sees only its ports. */
`timescale 1ns/1ps
module cms_chk
    import cms_pkg::*;
#(
    parameter int IDX_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire op_e op_kind,
    input wire logic writes_pending,
    input wire logic prefetch_pending,
    input wire logic [3:0] dirty_mask,
    input wire logic op_ready,
    input wire logic exec_busy,
    input wire logic eac_hold,
    input wire logic op_done,
    input wire logic chk_valid,
    input wire logic [IDX_W-1:0] chk_index,
    input wire logic buf_load_lo,
    input wire logic buf_load_hi,
    input wire logic transfer_start_strobe,
    input wire push_cmd_s push_cmd
);
    // ****************
    // Bookkeeping
    // ****************
    wire logic acc = op_valid && op_ready;
    wire logic drained = !writes_pending && !prefetch_pending;
    logic [15:0] cnt_q;
    logic [15:0] ndr_q;
    op_e kind_q;
    logic dirt_q;
    logic first_q;

    // Counts restart at acceptance, so a stale count never leaks into the next operation.
    always_ff @(posedge clk) begin
        if (!rst_n || acc) begin
            cnt_q <= 16'h0000;
            ndr_q <= 16'h0000;
            dirt_q <= 1'b0;
            first_q <= 1'b1;
        end else if (exec_busy) begin
            cnt_q <= cnt_q + 16'h0001;
            ndr_q <= ndr_q + {15'h0000, drained};
            dirt_q <= dirt_q | buf_load_lo | !drained;
            first_q <= first_q & !buf_load_lo;
        end
    end

    // The kind is kept because the operation input is free to change once taken.
    always_ff @(posedge clk) begin
        if (acc) begin
            kind_q <= op_kind;
        end
    end

    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_inv9;
        acc && (op_kind == line_invalidate_op || op_kind == whole_cache_invalidate_op)
            ##1 drained [*8] ##1 drained;
    endsequence
    sequence s_first_load;
        buf_load_lo && first_q ##1 buf_load_hi;
    endsequence

    property p_inv9;
        s_inv9 |-> op_done;
    endproperty
    a_inv9: assert property (p_inv9) else $error("short invalidate did not end on time");
    property p_inv_len;
        op_done && kind_q <= whole_cache_invalidate_op |->
            ndr_q + {15'h0000, drained} == (kind_q == page_invalidate_op ? 16'h010A : 16'h0009);
    endproperty
    a_inv_len: assert property (p_inv_len) else $error("invalidate length wrong");
    property p_push_best;
        op_done && kind_q >= line_push_op && !dirt_q && !buf_load_lo && drained |->
            cnt_q + 16'h0001 == (kind_q == line_push_op ? 16'h0006 : 16'h010B);
    endproperty
    a_push_best: assert property (p_push_best) else $error("clean push length wrong");
    property p_done_pulse;
        op_done |=> !op_done && op_ready;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("completion not a single pulse");
    property p_hold;
        (acc || (exec_busy && !op_done)) |=> eac_hold && !op_ready;
    endproperty
    a_hold: assert property (p_hold) else $error("address stage not held");
    property p_index_step;
        chk_valid && dirty_mask == 4'h0 && kind_q != line_push_op && chk_index != '1 |=>
            chk_index == IDX_W'($past(chk_index) + 1);
    endproperty
    a_index_step: assert property (p_index_step) else $error("index did not step");
    property p_first_start;
        s_first_load |=> transfer_start_strobe;
    endproperty
    a_first_start: assert property (p_first_start) else $error("transfer start late");
    property p_xfer_kind;
        transfer_start_strobe |-> push_cmd.line_xfer == ($countones(push_cmd.dirty) > 1);
    endproperty
    a_xfer_kind: assert property (p_xfer_kind) else $error("transfer size wrong");
    property p_no_early_end;
        transfer_start_strobe |=> !op_done [*3];
    endproperty
    a_no_early_end: assert property (p_no_early_end) else $error("push ended too early");
endmodule

bind cache_maintenance_sequencer cms_chk #(.IDX_W(IDX_W)) u_chk (.clk, .rst_n, .op_valid, .op_kind,
    .writes_pending, .prefetch_pending, .dirty_mask, .op_ready, .exec_busy, .eac_hold, .op_done,
    .chk_valid, .chk_index, .buf_load_lo, .buf_load_hi, .transfer_start_strobe, .push_cmd);

// [test/cms_mem_model.sv]
/* Memory side model: acknowledges each push beat after a settable wait.
   Assumes the start strobe and transfer size come from the sequencer. */
`timescale 1ns/1ps
module cms_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic transfer_start_strobe,
    input wire logic line_xfer,
    input wire logic [3:0] wait_states,
    output logic bus_cycle_acknowledge
);
    // ****************
    // Beat acknowledge
    // ****************
    // At least one low clock sits between beats so every beat is a separate pulse.
    initial begin
        bus_cycle_acknowledge = 1'b0;
        forever begin
            @(posedge clk);
            if (rst_n && transfer_start_strobe) begin
                repeat (line_xfer ? 4 : 1) begin
                    repeat (wait_states + 4'h1) @(posedge clk);
                    #1 bus_cycle_acknowledge = 1'b1;
                    @(posedge clk);
                    #1 bus_cycle_acknowledge = 1'b0;
                end
            end
        end
    end
endmodule

// [test/tb_top.sv]
/* Self-checking bench for the cache maintenance sequencer.
   Assumes the memory model answers pushes and dmap holds the dirty state. */
`timescale 1ns/1ps
module tb_top;
    import cms_pkg::*;
    // ****************
    // Signals
    // ****************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    op_e op_kind = line_invalidate_op;
    logic [1:0] cache_sel = 2'h0;
    logic [7:0] line_index = 8'h00;
    logic writes_pending = 1'b0;
    logic prefetch_pending = 1'b0;
    logic [3:0] wait_states = 4'h0;
    logic bus_cycle_acknowledge, op_ready, exec_busy, eac_hold, op_done, chk_valid;
    logic buf_load_lo, buf_load_hi, transfer_start_strobe;
    logic [7:0] chk_index;
    push_cmd_s push_cmd;
    logic [3:0] dmap [256];
    wire logic [3:0] dirty_mask = dmap[chk_index];
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    logic [7:0] idx_q [$];
    push_cmd_s cmd_q [$];

    cache_maintenance_sequencer #(.IDX_W(8)) uut (.clk, .rst_n, .op_valid, .op_kind, .cache_sel,
        .line_index, .writes_pending, .prefetch_pending, .dirty_mask, .bus_cycle_acknowledge, .op_ready,
        .exec_busy, .eac_hold, .op_done, .chk_valid, .chk_index, .buf_load_lo, .buf_load_hi,
        .transfer_start_strobe, .push_cmd);
    cms_mem_model mem (.clk, .rst_n, .transfer_start_strobe, .line_xfer(push_cmd.line_xfer),
        .wait_states, .bus_cycle_acknowledge);

    // Clock of 4 ns.
    initial begin
        forever #2 clk = ~clk;
    end

    // Records checked indices (repeats folded), transfer starts, and cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (chk_valid && (idx_q.size() == 0 || idx_q[$] !== chk_index)) idx_q.push_back(chk_index);
        if (transfer_start_strobe) cmd_q.push_back(push_cmd);
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    // ****************
    // Tasks
    // ****************
    task automatic cmp_n(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_cmd(input push_cmd_s got, input push_cmd_s exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Issues one operation and counts its busy clocks; pend clocks of drain precede it.
    task automatic run_op(input op_e k, input logic [1:0] sel, input int pend);
        logic d;
        n = 0;
        idx_q.delete();
        cmd_q.delete();
        op_kind = k;
        cache_sel = sel;
        op_valid = 1'b1;
        writes_pending = pend > 0 && sel[0];
        prefetch_pending = pend > 0 && !sel[0];
        @(posedge clk);
        #1;
        op_valid = 1'b0;
        do begin
            if (n >= pend) begin
                writes_pending = 1'b0;
                prefetch_pending = 1'b0;
            end
            n += exec_busy;
            d = op_done;
            @(posedge clk);
            #1;
        end while (!d && n < 5000);
    endtask

    task automatic sweep();
        cmp_n(idx_q.size(), 32'h100);
        for (int i = 0; i < 256; i++) cmp_n(idx_q[i], i);
    endtask

    task automatic t_invalidate();
        for (int k = 0; k < 3; k++) begin
            for (int s = 0; s < 4; s++) begin
                run_op(op_e'(k), 2'(s), 0);
                cmp_n(n, k == 1 ? 32'h10A : 32'h9);
            end
        end
        run_op(line_invalidate_op, 2'h1, 5);
        cmp_n(n, 32'hE);
        run_op(page_invalidate_op, 2'h2, 3);
        cmp_n(n, 32'h10D);
    endtask

    task automatic t_push_clean();
        line_index = 8'h2A;
        run_op(line_push_op, 2'h3, 0);
        cmp_n(n, 32'h6);
        cmp_n(idx_q[0], 32'h2A);
        for (int k = 4; k < 6; k++) begin
            run_op(op_e'(k), 2'h0, 0);
            cmp_n(n, 32'h10B);
            sweep();
        end
    endtask

    // Single dirty longword, clean line, then a full and a half-dirty line; memory prompt, then slow.
    task automatic t_push_dirty();
        dmap[4] = 4'h1;
        dmap[6] = 4'hF;
        dmap[7] = 4'h3;
        for (int k = 4; k < 6; k++) begin
            wait_states = (k == 4) ? 4'h0 : 4'h3;
            run_op(op_e'(k), 2'h1, 0);
            sweep();
            cmp_n(cmd_q.size(), 32'h3);
            cmp_cmd(cmd_q[0], {1'b0, 8'h04, 4'h1});
            cmp_cmd(cmd_q[1], {1'b1, 8'h06, 4'hF});
            cmp_cmd(cmd_q[2], {1'b1, 8'h07, 4'h3});
        end
        line_index = 8'h06;
        run_op(line_push_op, 2'h0, 0);
        cmp_cmd(cmd_q[0], {1'b1, 8'h06, 4'hF});
        foreach (dmap[i]) dmap[i] = 4'h0;
    endtask

    // A request held during a busy run is ignored; reset in mid-run returns to idle.
    task automatic t_reset();
        op_kind = page_invalidate_op;
        op_valid = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        op_valid = 1'b0;
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        cmp_n({op_ready, exec_busy, op_done}, 32'h4);
        run_op(line_invalidate_op, 2'h0, 0);
        cmp_n(n, 32'h9);
    endtask

    // ****************
    // Main sequence
    // ****************
    initial begin
        foreach (dmap[i]) dmap[i] = 4'h0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_invalidate();
        t_push_clean();
        t_push_dirty();
        t_reset();
        tally_and_finish();
    end
endmodule
